// >>> bench/fault_distance_locator_asserts.sv
// Port assertions for the fault distance locator
`timescale 1ns/100ps
`include "fault_locator_defs.vh"
module fault_distance_locator_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire inputs_connected,
  input wire blocked,
  input wire triggered,
  input wire calculating,
  input wire event_valid,
  input wire [1:0] event_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_calc_start;
    !calculating ##1 calculating;
  endsequence
  a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_event_pulse: assert property (event_valid |=>
    !event_valid || event_code != $past(event_code))
    else $error("event too long");
  a_trig_event: assert property (event_valid && event_code == `EVT_TRIG_ON |-> triggered)
    else $error("trigger event while idle");
  a_blocked_idle: assert property (blocked |-> !calculating)
    else $error("calculating while blocked");
  a_need_inputs: assert property (!inputs_connected |=> !$rose(triggered))
    else $error("trigger without inputs");
  a_calc_after_trig: assert property (s_calc_start |-> $past(triggered))
    else $error("calculation without trigger");
endmodule // fault_distance_locator_asserts
bind fault_distance_locator fault_distance_locator_asserts u_fault_distance_locator_asserts (.*);

// >>> bench/fault_distance_locator_bench.sv
// Self-checking bench for the fault distance locator
`timescale 1ns/100ps
`include "fault_locator_defs.vh"
module fault_distance_locator_bench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] ad = 8'h00;
  reg [31:0] wd = 32'h0, tm = 32'h0, rd, etm = 32'h0;
  reg awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, fire = 1'b0;
  reg blk = 1'b0, blk_in = 1'b0, pe = 1'b0, pv, conn = 1'b1, ta, tw, tr, hit;
  reg [15:0] cur [0:2];
  reg [15:0] xr [0:5];
  reg [15:0] xp = `XPERKM_RESET, xe;
  reg [1:0] dir = 2'h0, rr;
  reg [2:0] grp = 3'h0, ov, lp;
  integer err_count = 0, samples_checked = 0, i, j, n, kind, nrec = 0, ecnt = 0, evn = 0;
  wire awr, wr, bv, arr, rv, cyc, blocked, ev_v;
  wire [1:0] rrs;
  wire [31:0] rdat, ev_t;
  wire [7:0] tsrc, bsrc;
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    tm <= tm + 32'h1;
    if (ev_v) evn <= evn + 1;
    if (ev_v) etm <= tm - 32'h1;
  end
  fault_distance_locator u_fault_distance_locator (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(ad), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ad), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry), .cycle_start(cyc),
    .trigger_sources(tsrc), .trigger_select(8'h04), .block_sources(bsrc),
    .block_select(8'h10), .block_input(blk_in), .pe_voltage_ok(pe), .inputs_connected(conn),
    .current_l1(cur[0]), .current_l2(cur[1]), .current_l3(cur[2]),
    .current_primary(16'h0064), .reactance_l12(xr[0]), .reactance_l23(xr[1]),
    .reactance_l31(xr[2]), .reactance_l1(xr[3]), .reactance_l2(xr[4]), .reactance_l3(xr[5]),
    .fault_direction(dir), .setting_group(grp), .time_ms(tm), .blocked(blocked),
    .triggered(), .calculating(), .event_valid(ev_v), .event_code(), .event_time(ev_t));
  trip_source_model u_trip_source_model (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .blk(blk), .cycle_start(cyc), .trigger_sources(tsrc), .block_sources(bsrc));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // One AXI4-Lite transfer, held until each channel is taken
  task axi(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      ad <= a;
      wd <= d;
      {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
      hit = 1'b0;
      for (n = 0; n < 60 && !hit; n = n + 1) begin
        @(negedge aclk);
        {ta, tw, tr, rd, rr} = {awr, wr, arr, rdat, rrs};
        hit = w ? bv : rv;
        @(posedge aclk);
        {awv, wv, arv} <= {awv && !ta, wv && !tw, arv && !tr};
      end
      {bry, rry} <= 2'b00;
      if (!hit) err_count = err_count + 1;
      if (!hit) results;
    end
  endtask
  function [2:0] exp_loop(input [2:0] o, input p);
    exp_loop = o == 3'h7 ? `LOOP_L123 : o == 3'h3 ? `LOOP_L12 : o == 3'h6 ? `LOOP_L23 :
      o == 3'h5 ? `LOOP_L31 : !p ? `LOOP_NONE : o == 3'h1 ? `LOOP_L1N :
      o == 3'h2 ? `LOOP_L2N : o == 3'h4 ? `LOOP_L3N : `LOOP_NONE;
  endfunction
  initial begin
    n = $urandom(4);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi(0, `ADDR_CTRL, 0);
    chk(rd, `CTRL_RESET);
    axi(0, `ADDR_THRESH, 0);
    chk(rd, `THRESH_RESET);
    axi(0, `ADDR_XPERKM, 0);
    chk(rd, `XPERKM_RESET);
    axi(0, 8'hFC, 0);
    chk(rr, `RESP_SLVERR);
    axi(1, `ADDR_CTRL, 32'h0000000D);
    $display("register test done");
    for (i = 0; i < 23; i = i + 1) begin
      kind = i < 20 ? 0 : i - 19;
      if (i == 10) xp = 16'h0032 + $urandom % 400;
      if (i == 10) axi(1, `ADDR_XPERKM, xp);
      ov = i < 16 ? i : kind != 0 ? 3'h7 : $urandom;
      pv = i < 16 ? i[3] : $urandom;
      for (j = 0; j < 6; j = j + 1) begin
        xr[j] <= 16'h0001 + $urandom % 4000;
        if (j < 3) cur[j] <= ov[j] ? 16'h000B + $urandom % 40 : $urandom % 11;
      end
      {pe, dir} <= {pv, 2'($urandom % 3)};
      grp <= $urandom;
      {blk_in, blk, conn} <= {kind == 1, kind == 2, kind != 3};
      repeat (30) @(posedge aclk);
      fire <= !fire;
      repeat (40) @(posedge aclk);
      lp = exp_loop(ov, pv);
      if (kind != 3) ecnt = ecnt + 1;
      chk(blocked, kind != 0);
      axi(0, `ADDR_COUNT, 0);
      chk(rd, ecnt);
      chk(ev_t, etm);
      if (kind == 0 && lp != `LOOP_NONE) begin
        axi(1, `ADDR_LOG_SEL, nrec % 12);
        xe = xr[lp == `LOOP_L123 ? 0 : lp - 1];
        axi(0, `ADDR_LOG_INFO, 0);
        chk(rd, {8'h00, grp, dir, lp, xe});
        axi(0, `ADDR_LOG_DIST, 0);
        chk(rd, xe / xp);
        nrec = nrec + 1;
      end
      axi(0, `ADDR_STATUS, 0);
      chk(rd[11:8], nrec < 12 ? nrec : 12);
      $display("trigger test %0d done", i);
    end
    j = evn;
    chk(j != 0, 1'b1);
    conn <= 1'b1;
    axi(1, `ADDR_CTRL, 32'h00000001);
    repeat (30) @(posedge aclk);
    fire <= !fire;
    repeat (40) @(posedge aclk);
    chk(evn, j);
    axi(1, `ADDR_CTRL, 32'h00000003);
    axi(0, `ADDR_COUNT, 0);
    chk(rd, 0);
    $display("event filter and clear test done");
    results;
  end
endmodule // fault_distance_locator_bench

// >>> bench/trip_source_model.sv
// Far-side model: program cycle tick and trip sources
`timescale 1ns/100ps
module trip_source_model (
  input wire aclk,
  input wire aresetn,
  input wire fire,
  input wire blk,
  output reg cycle_start,
  output reg [7:0] trigger_sources,
  output reg [7:0] block_sources
);
  reg [3:0] tick, hold;
  reg last;
  always @(posedge aclk) begin
    tick <= aresetn ? tick + 4'h1 : 4'h0;
    cycle_start <= tick == 4'h7;
    last <= fire;
    hold <= !aresetn ? 4'h0 : fire != last ? 4'hA : hold - (hold != 4'h0);
    trigger_sources <= {5'h00, hold != 4'h0, 2'h0};
    block_sources <= {3'h0, blk, 4'h0};
  end
endmodule // trip_source_model

// >>> design/fault_distance_locator.v
// Fault distance locator with AXI4-Lite register access
// Functional notes
// - Start an attempt when the selected binary trigger source rises.
// - Abandon the attempt without record if a selected block input is active.
// - Without phase-to-earth voltages only phase-to-phase loops are recorded.
// - Three phases give L123 with the L12 reactance; L1,L2 give L12; L2,L3 give L23; L1,L3 give L31.
// - Single phase over threshold records its earth loop only with voltages.
// - No phase over threshold means nothing recorded.
// - Current threshold in tenths of nominal, default one times nominal.
// - Line_reactance_per_length setting in 0.001 ohm steps, default 0.125.
// - Loop reactances come from fundamental components supplied outside.
// - Dedicated block input sampled at each program cycle start.
// - Block active at pick-up gives blocked indication, attempt dropped.
// - ON and OFF events for triggered and calculation, enabled per kind.
// - Every event carries a time stamp.
// - Cumulative trigger counter cleared by software.
// - Rolling log of last 12 records, oldest dropped.
// - Record holds time, event, loop, direction, X, currents, distance, group.
// - Active setting group may change parameters while running; here setting_group is only stored in the record, thresh and xperkm are single.
// - Operates only with all three currents and voltages connected.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "fault_locator_defs.vh"
module fault_distance_locator #(
  parameter NSRC = 8,
  parameter CW = 16,
  parameter TW = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cycle_start,
  input wire [NSRC-1:0] trigger_sources,
  input wire [NSRC-1:0] trigger_select,
  input wire [NSRC-1:0] block_sources,
  input wire [NSRC-1:0] block_select,
  input wire block_input,
  input wire pe_voltage_ok,
  input wire inputs_connected,
  input wire [CW-1:0] current_l1,
  input wire [CW-1:0] current_l2,
  input wire [CW-1:0] current_l3,
  input wire [CW-1:0] current_primary,
  input wire [CW-1:0] reactance_l12,
  input wire [CW-1:0] reactance_l23,
  input wire [CW-1:0] reactance_l31,
  input wire [CW-1:0] reactance_l1,
  input wire [CW-1:0] reactance_l2,
  input wire [CW-1:0] reactance_l3,
  input wire [1:0] fault_direction,
  input wire [2:0] setting_group,
  input wire [TW-1:0] time_ms,
  output reg blocked,
  output reg triggered,
  output reg calculating,
  output reg event_valid,
  output reg [1:0] event_code,
  output reg [TW-1:0] event_time
);
  // Evaluation sequence states
  localparam ST_IDLE = 2'h0;
  localparam ST_EVAL = 2'h1;
  localparam ST_DIV = 2'h2;
  localparam ST_LOG = 2'h3;

  // Settings and log storage
  reg [31:0] ctrl;
  reg [15:0] thresh;
  reg [15:0] xperkm;
  reg [31:0] count;
  reg [3:0] log_sel;
  reg [3:0] wr_ptr;
  reg [3:0] log_fill;
  reg [TW-1:0] log_time [0:`LOG_DEPTH-1];
  reg [31:0] log_info [0:`LOG_DEPTH-1];
  reg [31:0] log_curr [0:`LOG_DEPTH-1];
  reg [31:0] log_dist [0:`LOG_DEPTH-1];
  // Captured fault data and divider
  reg [1:0] state;
  reg [2:0] loop;
  reg [CW-1:0] x_sel;
  reg [CW-1:0] i_pu;
  reg [CW-1:0] i_pri;
  reg [31:0] rem;
  reg [15:0] quot;
  reg [4:0] div_i;
  reg trig_prev;
  reg blk_s1;
  reg blk_s2;
  reg blk_sample;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] next_loop;
  reg [CW-1:0] next_x;
  // Trigger and block conditions
  wire trig_now = |(trigger_sources & trigger_select);
  wire trig_rise = trig_now & ~trig_prev & ctrl[`CTRL_EN] & inputs_connected;
  wire calc_blocked = |(block_sources & block_select);
  wire [CW-1:0] thr_scaled = thresh[CW-1:0];
  // Strict compare against the threshold in tenths of nominal
  wire o1 = current_l1 > thr_scaled;
  wire o2 = current_l2 > thr_scaled;
  wire o3 = current_l3 > thr_scaled;
  // Next dividend bit, reactance msb first
  wire [4:0] div_bit_idx = div_i - 5'h01;
  wire div_bit = x_sel[div_bit_idx[3:0]];
  wire [32:0] trial = {rem, div_bit} - {17'h00000, xperkm};
  wire do_write = aw_held & w_held & ~s_axi_bvalid;

  // Loop choice from the phases over threshold
  always @* begin
    next_loop = `LOOP_NONE;
    next_x = {CW{1'b0}};
    case ({o1, o2, o3})
      3'b111: begin
        next_loop = `LOOP_L123;
        next_x = reactance_l12;
      end
      3'b110: begin
        next_loop = `LOOP_L12;
        next_x = reactance_l12;
      end
      3'b011: begin
        next_loop = `LOOP_L23;
        next_x = reactance_l23;
      end
      3'b101: begin
        next_loop = `LOOP_L31;
        next_x = reactance_l31;
      end
      3'b100: begin
        next_loop = pe_voltage_ok ? `LOOP_L1N : `LOOP_NONE;
        next_x = reactance_l1;
      end
      3'b010: begin
        next_loop = pe_voltage_ok ? `LOOP_L2N : `LOOP_NONE;
        next_x = reactance_l2;
      end
      3'b001: begin
        next_loop = pe_voltage_ok ? `LOOP_L3N : `LOOP_NONE;
        next_x = reactance_l3;
      end
      default: begin
        next_loop = `LOOP_NONE;
        next_x = {CW{1'b0}};
      end
    endcase
  end

  // Block input synchroniser and program cycle sample
  always @(posedge aclk) begin
    if (!aresetn) begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
      blk_sample <= 1'b0;
    end else begin
      blk_s1 <= block_input;
      blk_s2 <= blk_s1;
      if (cycle_start)
        blk_sample <= blk_s2;
    end
  end

  // Evaluation sequence, log and events
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      trig_prev <= 1'b0;
      loop <= `LOOP_NONE;
      x_sel <= {CW{1'b0}};
      i_pu <= {CW{1'b0}};
      i_pri <= {CW{1'b0}};
      rem <= 32'h00000000;
      quot <= 16'h0000;
      div_i <= 5'h00;
      blocked <= 1'b0;
      triggered <= 1'b0;
      calculating <= 1'b0;
      event_valid <= 1'b0;
      event_code <= `EVT_TRIG_ON;
      event_time <= {TW{1'b0}};
      count <= 32'h00000000;
      wr_ptr <= 4'h0;
      log_fill <= 4'h0;
    end else begin
      trig_prev <= trig_now;
      event_valid <= 1'b0;
      // A trigger in the clear cycle overrides the clear: count becomes count + 1
      if (do_write && aw_addr == `ADDR_CTRL && w_strb[0] && w_data[`CTRL_CLR_CNT])
        count <= 32'h00000000;
      case (state)
        ST_IDLE: begin
          // Trigger gone: OFF event
          if (!trig_now && triggered) begin
            triggered <= 1'b0;
            event_valid <= ctrl[`CTRL_EVT_OFF];
            event_code <= `EVT_TRIG_OFF;
            event_time <= time_ms;
          end
          // Rising trigger: ON event, then block check and loop choice
          if (trig_rise) begin
            count <= count + 32'h00000001;
            triggered <= 1'b1;
            event_valid <= ctrl[`CTRL_EVT_ON];
            event_code <= `EVT_TRIG_ON;
            event_time <= time_ms;
            // Block wins over any loop choice
            if (blk_sample || calc_blocked) begin
              blocked <= 1'b1;
            end else begin
              blocked <= 1'b0;
              loop <= next_loop;
              x_sel <= next_x;
              i_pu <= o1 ? current_l1 : (o2 ? current_l2 : current_l3);
              i_pri <= current_primary;
              state <= ST_EVAL;
            end
          end
        end
        ST_EVAL: begin
          // No eligible loop or zero setting: nothing recorded
          if (loop == `LOOP_NONE || xperkm == 16'h0000) begin
            state <= ST_IDLE;
          end else begin
            calculating <= 1'b1;
            event_valid <= ctrl[`CTRL_EVT_ON];
            event_code <= `EVT_CALC_ON;
            event_time <= time_ms;
            rem <= 32'h00000000;
            quot <= 16'h0000;
            div_i <= `DIV_STEPS;
            state <= ST_DIV;
          end
        end
        ST_DIV: begin
          // Restoring divide, one quotient bit per cycle
          if (div_i == 5'h00) begin
            state <= ST_LOG;
          end else begin
            if (!trial[32]) begin
              rem <= trial[31:0];
              quot <= {quot[14:0], 1'b1};
            end else begin
              rem <= {rem[30:0], div_bit};
              quot <= {quot[14:0], 1'b0};
            end
            div_i <= div_i - 5'h01;
          end
        end
        ST_LOG: begin
          // Record goes to the oldest slot
          log_time[wr_ptr] <= event_time;
          log_info[wr_ptr] <= {8'h00, setting_group, fault_direction, loop, x_sel};
          log_curr[wr_ptr] <= {i_pri, i_pu};
          log_dist[wr_ptr] <= {16'h0000, quot};
          wr_ptr <= (wr_ptr == `LOG_DEPTH - 1) ? 4'h0 : wr_ptr + 4'h1;
          if (log_fill != `LOG_DEPTH)
            log_fill <= log_fill + 4'h1;
          calculating <= 1'b0;
          event_valid <= ctrl[`CTRL_EVT_OFF];
          event_code <= `EVT_CALC_OFF;
          event_time <= time_ms;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Selected log slot; a slot number past the depth reads as zero
  wire log_ok = log_sel < `LOG_DEPTH;
  wire [TW-1:0] sel_time = log_ok ? log_time[log_sel] : {TW{1'b0}};
  wire [31:0] sel_info = log_ok ? log_info[log_sel] : 32'h00000000;
  wire [31:0] sel_curr = log_ok ? log_curr[log_sel] : 32'h00000000;
  wire [31:0] sel_dist = log_ok ? log_dist[log_sel] : 32'h00000000;

  // AXI4-Lite slave
  // Readies drop while a word is held
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl <= `CTRL_RESET;
      thresh <= `THRESH_RESET;
      xperkm <= `XPERKM_RESET;
      log_sel <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        // Unmapped write offsets answer SLVERR
        case (aw_addr)
          `ADDR_CTRL: if (w_strb[0]) ctrl <= {28'h0000000, w_data[3:2], 1'b0, w_data[0]};
          `ADDR_THRESH: if (w_strb[0]) thresh <= {7'h00, w_strb[1] ? w_data[8] : thresh[8],
                                                  w_data[7:0]};
          `ADDR_XPERKM: if (w_strb[0]) xperkm <= {3'h0, w_strb[1] ? w_data[12:8] : xperkm[12:8],
                                                  w_data[7:0]};
          `ADDR_LOG_SEL: if (w_strb[0]) log_sel <= w_data[3:0];
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        // Unmapped read offsets answer SLVERR with zero data
        case (s_axi_araddr)
          `ADDR_CTRL: s_axi_rdata <= ctrl;
          `ADDR_THRESH: s_axi_rdata <= {16'h0000, thresh};
          `ADDR_XPERKM: s_axi_rdata <= {16'h0000, xperkm};
          `ADDR_STATUS: s_axi_rdata <= {20'h00000, log_fill, wr_ptr, 1'b0, calculating,
                                        triggered, blocked};
          `ADDR_COUNT: s_axi_rdata <= count;
          `ADDR_TIME_LO: s_axi_rdata <= event_time;
          `ADDR_LOG_SEL: s_axi_rdata <= {28'h0000000, log_sel};
          `ADDR_LOG_BASE: s_axi_rdata <= sel_time;
          `ADDR_LOG_INFO: s_axi_rdata <= sel_info;
          `ADDR_LOG_CURR: s_axi_rdata <= sel_curr;
          `ADDR_LOG_DIST: s_axi_rdata <= sel_dist;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // fault_distance_locator

// >>> design/fault_locator_defs.vh
// Constants for the fault distance locator
`ifndef FAULT_LOCATOR_DEFS_VH
`define FAULT_LOCATOR_DEFS_VH
`define ADDR_CTRL 8'h00
`define ADDR_THRESH 8'h04
`define ADDR_XPERKM 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_COUNT 8'h10
`define ADDR_TIME_LO 8'h14
`define ADDR_LOG_SEL 8'h18
`define ADDR_LOG_BASE 8'h20
`define CTRL_EN 0
`define CTRL_CLR_CNT 1
`define CTRL_EVT_ON 2
`define CTRL_EVT_OFF 3
`define CTRL_RESET 32'h0000000C
`define THRESH_RESET 16'h000A
`define XPERKM_RESET 16'h007D
`define LOG_DEPTH 12
`define ADDR_LOG_INFO 8'h24
`define ADDR_LOG_CURR 8'h28
`define ADDR_LOG_DIST 8'h2C
`define DIV_STEPS 5'h10
`define LOOP_NONE 3'h0
`define LOOP_L12 3'h1
`define LOOP_L23 3'h2
`define LOOP_L31 3'h3
`define LOOP_L1N 3'h4
`define LOOP_L2N 3'h5
`define LOOP_L3N 3'h6
`define LOOP_L123 3'h7
`define EVT_TRIG_ON 2'h0
`define EVT_TRIG_OFF 2'h1
`define EVT_CALC_ON 2'h2
`define EVT_CALC_OFF 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define MS_NS 1000000
`define CLK_NS 25
`endif
